// ===== core/alc_capture_top.sv
`timescale 1ns/1ps
`default_nettype none
module alc_capture_top #(
  parameter logic [8:0] INIT_TAP_DELAY = alc_pkg::RST_TAP,
  parameter logic [1:0] INIT_LED_SELECT = alc_pkg::RST_LED_SEL,
  parameter logic [15:0] INIT_OVLD_THRESH = alc_pkg::RST_THRESH,
  parameter int BUF_DEPTH = 2
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] data_pair_pos_in,
  input wire logic [7:0] data_pair_neg_in,
  input wire logic sample_clk_in,
  input wire logic ext_led_src_in,
  output logic power_down_out,
  output logic dither_out,
  output logic ovld_led_n_out,
  output logic adc_ovld_out,
  output logic trim_ovld_out,
  output logic [8:0] tap_delay_out,
  output logic tap_load_out,
  input wire logic [6:0] s_axi_csr_awaddr_in,
  input wire logic s_axi_csr_awvalid_in,
  output logic s_axi_csr_awready_out,
  input wire logic [31:0] s_axi_csr_wdata_in,
  input wire logic [3:0] s_axi_csr_wstrb_in,
  input wire logic s_axi_csr_wvalid_in,
  output logic s_axi_csr_wready_out,
  output logic [1:0] s_axi_csr_bresp_out,
  output logic s_axi_csr_bvalid_out,
  input wire logic s_axi_csr_bready_in,
  input wire logic [6:0] s_axi_csr_araddr_in,
  input wire logic s_axi_csr_arvalid_in,
  output logic s_axi_csr_arready_out,
  output logic [31:0] s_axi_csr_rdata_out,
  output logic [1:0] s_axi_csr_rresp_out,
  output logic s_axi_csr_rvalid_out,
  input wire logic s_axi_csr_rready_in,
  output logic irq_out,
  output logic [15:0] m_axis_tdata_out,
  output logic m_axis_tvalid_out,
  input wire logic m_axis_tready_in
);
  import alc_pkg::*;

  localparam alc_tap_s TAP_INIT = '{rsvd: '0, load: 1'b0,
    tap: INIT_TAP_DELAY};
  localparam alc_mode_s MODE_INIT = '{thresh: INIT_OVLD_THRESH,
    rsvd: '0, led_sel: INIT_LED_SELECT, pwdn: RST_PWDN,
    dither: RST_DITHER, twos: RST_TWOS, int_dly: RST_INT_DLY};
  localparam alc_trim_s TRIM_INIT = '{gain: RST_GAIN, offset: RST_OFFSET};

  // Capture state
  logic [16:0] pin_s1, pin_sync;
  logic [8:0] pin_s2;
  logic clk_s3;
  logic [7:0] even_bits, next_even_bits;
  logic [15:0] raw_word, next_raw_word;
  logic raw_stb, next_raw_stb;

  // Differential decode only after both synchroniser stages
  assign pin_s2 = {pin_sync[16], pin_sync[7:0] & ~pin_sync[15:8]};

  // Even bits on rising sample clock, odd bits and word on falling
  always_comb begin
    next_even_bits = even_bits;
    next_raw_word = raw_word;
    next_raw_stb = 1'b0;
    if (pin_s2[8] && !clk_s3) begin
      next_even_bits = pin_s2[7:0];
    end
    if (!pin_s2[8] && clk_s3) begin
      for (int k = 0; k < 8; k++) begin
        next_raw_word[2*k] = even_bits[k];
        next_raw_word[2*k+1] = pin_s2[k];
      end
      next_raw_stb = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_s1 <= '0;
      pin_sync <= '0;
      clk_s3 <= 1'b0;
      even_bits <= '0;
      raw_word <= '0;
      raw_stb <= 1'b0;
    end else begin
      pin_s1 <= {sample_clk_in, data_pair_neg_in, data_pair_pos_in};
      pin_sync <= pin_s1;
      clk_s3 <= pin_s2[8];
      even_bits <= next_even_bits;
      raw_word <= next_raw_word;
      raw_stb <= next_raw_stb;
    end
  end

  // Register state
  alc_tap_s tap_reg, next_tap_reg;
  alc_mode_s mode, next_mode;
  alc_trim_s trim, next_trim;
  alc_irq_s ien, next_ien, flags, next_flags, status_q, status;
  alc_irq_s rise, clr;
  logic irq, next_irq, tap_load, next_tap_load;
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic wr_go, rd_go;
  logic [6:0] wr_word, rd_word;

  // Sample path state
  logic [3:0][15:0] dline, next_dline;
  logic [15:0] ovl_cnt, next_ovl_cnt, adc_word, next_adc_word;
  logic adc_stb, next_adc_stb, adc_ovld, next_adc_ovld;
  logic [15:0] out_word, next_out_word;
  logic out_valid, next_out_valid, trim_ovld, next_trim_ovld;
  logic buf_in_ready, led_n, next_led_n;

  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] wd, input logic [3:0] st, input logic [31:0] msk);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r & msk;
  endfunction

  // Bus handshakes, one write and one read at a time
  assign wr_go = s_axi_csr_awvalid_in && s_axi_csr_wvalid_in && !bvalid;
  assign rd_go = s_axi_csr_arvalid_in && !rvalid;
  assign s_axi_csr_awready_out = wr_go;
  assign s_axi_csr_wready_out = wr_go;
  assign s_axi_csr_arready_out = rd_go;
  assign wr_word = {s_axi_csr_awaddr_in[6:2], 2'b00};
  assign rd_word = {s_axi_csr_araddr_in[6:2], 2'b00};
  assign status = '{trim_ovld: trim_ovld, adc_ovld: adc_ovld};
  assign rise = status & ~status_q;
  assign clr = (rd_go && rd_word == OFS_IFLG) ? flags : '0;

  // Register writes, reads, flags and interrupt
  always_comb begin
    next_tap_reg = tap_reg;
    next_mode = mode;
    next_trim = trim;
    next_ien = ien;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    if (wr_go) begin
      next_bvalid = 1'b1;
      next_bresp = (s_axi_csr_awaddr_in >= OFS_LIMIT) ? RESP_DECERR :
        RESP_OKAY;
      unique case (wr_word)
        OFS_TAP: next_tap_reg = merge(tap_reg, s_axi_csr_wdata_in,
          s_axi_csr_wstrb_in, MASK_TAP);
        OFS_MODE: next_mode = merge(mode, s_axi_csr_wdata_in,
          s_axi_csr_wstrb_in, MASK_MODE);
        OFS_TRIM: next_trim = merge(trim, s_axi_csr_wdata_in,
          s_axi_csr_wstrb_in, MASK_TRIM);
        OFS_IEN: next_ien = 2'(merge(32'(ien), s_axi_csr_wdata_in,
          s_axi_csr_wstrb_in, MASK_IEN));
        default: next_ien = ien;
      endcase
    end else if (s_axi_csr_bready_in) begin
      next_bvalid = 1'b0;
    end
    if (rd_go) begin
      next_rvalid = 1'b1;
      next_rresp = (s_axi_csr_araddr_in >= OFS_LIMIT) ? RESP_DECERR :
        RESP_OKAY;
      unique case (rd_word)
        OFS_TAP: next_rdata = tap_reg;
        OFS_MODE: next_rdata = mode;
        OFS_TRIM: next_rdata = trim;
        OFS_IEN: next_rdata = {30'h0, ien};
        OFS_ISRC: next_rdata = {30'h0, status};
        OFS_IFLG: next_rdata = {30'h0, flags};
        default: next_rdata = 32'h0;
      endcase
    end else if (s_axi_csr_rready_in) begin
      next_rvalid = 1'b0;
    end
    next_tap_load = tap_reg.load && !next_tap_reg.load;
    next_flags = (flags & ~clr) | rise;
    // Events in adjacent cycles merge into one pulse
    next_irq = !irq && |(rise & ien & (~flags | clr));
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tap_reg <= TAP_INIT;
      mode <= MODE_INIT;
      trim <= TRIM_INIT;
      ien <= RST_IEN;
      flags <= '0;
      status_q <= '0;
      irq <= 1'b0;
      tap_load <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= 32'h0;
    end else begin
      tap_reg <= next_tap_reg;
      mode <= next_mode;
      trim <= next_trim;
      ien <= next_ien;
      flags <= next_flags;
      status_q <= status;
      irq <= next_irq;
      tap_load <= next_tap_load;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  // Format, integer delay and input overload detection
  always_comb begin
    next_dline = dline;
    next_ovl_cnt = ovl_cnt;
    next_adc_word = adc_word;
    next_adc_stb = 1'b0;
    next_adc_ovld = adc_ovld;
    if (raw_stb) begin
      next_dline = {dline[2:0], raw_word ^ {mode.twos, 15'h0000}};
      next_adc_word = next_dline[mode.int_dly];
      next_adc_stb = 1'b1;
      if (next_adc_word == FS_POS || next_adc_word == FS_NEG) begin
        next_ovl_cnt = (ovl_cnt == CNT_MAX) ? ovl_cnt : ovl_cnt + 1'b1;
        next_adc_ovld = (next_ovl_cnt >= mode.thresh);
      end else begin
        next_ovl_cnt = 16'h0000;
        next_adc_ovld = 1'b0;
      end
    end
  end

  // Gain and offset trim with saturation
  logic signed [31:0] prod;
  logic signed [18:0] sum;
  logic sat_hi, sat_lo;
  logic [15:0] trimmed;
  always_comb begin
    prod = $signed(adc_word) * $signed(trim.gain);
    sum = 19'(prod >>> GAIN_FRAC) + 19'($signed(trim.offset));
    sat_hi = (sum > SAT_MAX);
    sat_lo = (sum < SAT_MIN);
    trimmed = sat_hi ? FS_POS : (sat_lo ? FS_NEG : sum[15:0]);
  end

  // Output stage held while the buffer is full
  always_comb begin
    next_out_word = out_word;
    next_out_valid = out_valid;
    next_trim_ovld = trim_ovld;
    if (out_valid && buf_in_ready) begin
      next_out_valid = 1'b0;
    end
    if (adc_stb && (!out_valid || buf_in_ready)) begin
      next_out_word = trimmed;
      next_out_valid = 1'b1;
      next_trim_ovld = sat_hi || sat_lo;
    end
  end

  // LED source selection
  always_comb begin
    unique case (alc_led_e'(mode.led_sel))
      LED_INPUT: next_led_n = !adc_ovld;
      LED_TRIM: next_led_n = !trim_ovld;
      LED_EXT: next_led_n = !ext_led_src_in;
      LED_OFF: next_led_n = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dline <= '0;
      ovl_cnt <= 16'h0000;
      adc_word <= 16'h0000;
      adc_stb <= 1'b0;
      adc_ovld <= 1'b0;
      out_word <= 16'h0000;
      out_valid <= 1'b0;
      trim_ovld <= 1'b0;
      led_n <= 1'b1;
    end else begin
      dline <= next_dline;
      ovl_cnt <= next_ovl_cnt;
      adc_word <= next_adc_word;
      adc_stb <= next_adc_stb;
      adc_ovld <= next_adc_ovld;
      out_word <= next_out_word;
      out_valid <= next_out_valid;
      trim_ovld <= next_trim_ovld;
      led_n <= next_led_n;
    end
  end

  alc_skid_buf #(.WIDTH(16), .DEPTH(BUF_DEPTH)) u_buf (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .in_data_in(out_word),
    .in_valid_in(out_valid),
    .in_ready_out(buf_in_ready),
    .out_data_out(m_axis_tdata_out),
    .out_valid_out(m_axis_tvalid_out),
    .out_ready_in(m_axis_tready_in)
  );

  // Pins and bus outputs from registers
  assign power_down_out = mode.pwdn;
  assign dither_out = mode.dither;
  assign ovld_led_n_out = led_n;
  assign adc_ovld_out = adc_ovld;
  assign trim_ovld_out = trim_ovld;
  assign tap_delay_out = tap_reg.tap;
  assign tap_load_out = tap_load;
  assign irq_out = irq;
  assign s_axi_csr_bresp_out = bresp;
  assign s_axi_csr_bvalid_out = bvalid;
  assign s_axi_csr_rdata_out = rdata;
  assign s_axi_csr_rresp_out = rresp;
  assign s_axi_csr_rvalid_out = rvalid;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  logic mode_wr;
  assign mode_wr = wr_go && wr_word == OFS_MODE && s_axi_csr_wstrb_in[0];

  a_word_pairing: assert property (raw_stb |-> raw_word[1:0] ==
    {$past(pin_s2[0]), $past(even_bits[0])})
    else $error("pair bits misplaced in word");
  a_word_on_fall: assert property (raw_stb |->
    $past(clk_s3) && !$past(pin_s2[8]))
    else $error("word not tied to falling sample clock");
  a_pwdn_write: assert property (mode_wr |=>
    power_down_out == $past(s_axi_csr_wdata_in[4]))
    else $error("power-down pin missed write");
  a_dither_write: assert property (mode_wr |=>
    dither_out == $past(s_axi_csr_wdata_in[3]))
    else $error("dither pin missed write");
  a_led_ext: assert property ($past(mode.led_sel) == LED_EXT |->
    ovld_led_n_out == !$past(ext_led_src_in))
    else $error("led does not follow external source");
  a_led_off: assert property ($past(mode.led_sel) == LED_OFF |->
    ovld_led_n_out)
    else $error("led lit while disabled");
  a_ovld_fullscale: assert property ($rose(adc_ovld_out) |->
    adc_word == FS_POS || adc_word == FS_NEG)
    else $error("input overload without full scale");
  a_trim_saturates: assert property ($rose(trim_ovld_out) |->
    out_word == FS_POS || out_word == FS_NEG)
    else $error("trim overload without saturation");
  a_flag_latch: assert property (|rise |=>
    (flags & $past(rise)) == $past(rise))
    else $error("flag missed rising source");
  a_irq_pulse: assert property (irq_out |=> !irq_out)
    else $error("interrupt wider than one cycle");
  a_rd_decode: assert property (rd_go && s_axi_csr_araddr_in >= OFS_LIMIT
    |=> s_axi_csr_rvalid_out && s_axi_csr_rresp_out == RESP_DECERR)
    else $error("unmapped read not refused");

  c_irq_seen: cover property (irq_out);
  c_led_lit: cover property (!ovld_led_n_out);
  c_flag_cleared: cover property (|clr ##1 flags == '0);
  c_stream_beat: cover property (m_axis_tvalid_out && m_axis_tready_in);
endmodule
`default_nettype wire

// ===== core/alc_pkg.sv
`default_nettype none
package alc_pkg;
  // Register offsets
  localparam logic [6:0] OFS_TAP = 7'h00;
  localparam logic [6:0] OFS_MODE = 7'h04;
  localparam logic [6:0] OFS_TRIM = 7'h08;
  localparam logic [6:0] OFS_RSVD_A = 7'h0C;
  localparam logic [6:0] OFS_RSVD_B = 7'h10;
  localparam logic [6:0] OFS_IEN = 7'h14;
  localparam logic [6:0] OFS_ISRC = 7'h18;
  localparam logic [6:0] OFS_IFLG = 7'h1C;
  localparam logic [6:0] OFS_LIMIT = 7'h20;
  // Writable bit masks
  localparam logic [31:0] MASK_TAP = 32'h000003FF;
  localparam logic [31:0] MASK_MODE = 32'hFFFF007F;
  localparam logic [31:0] MASK_TRIM = 32'hFFFFFFFF;
  localparam logic [31:0] MASK_IEN = 32'h00000003;
  // Reset values
  localparam logic [8:0] RST_TAP = 9'h000;
  localparam logic [15:0] RST_THRESH = 16'h0004;
  localparam logic [1:0] RST_LED_SEL = 2'h0;
  localparam logic RST_PWDN = 1'b0;
  localparam logic RST_DITHER = 1'b0;
  localparam logic RST_TWOS = 1'b0;
  localparam logic [1:0] RST_INT_DLY = 2'h0;
  localparam logic [15:0] RST_GAIN = 16'h4000;
  localparam logic [15:0] RST_OFFSET = 16'h0000;
  localparam logic [1:0] RST_IEN = 2'h0;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Sample arithmetic
  localparam int GAIN_FRAC = 14;
  localparam logic [15:0] FS_POS = 16'h7FFF;
  localparam logic [15:0] FS_NEG = 16'h8000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic signed [18:0] SAT_MAX = 19'sh07FFF;
  localparam logic signed [18:0] SAT_MIN = 19'sh78000;

  typedef enum logic [1:0] {
    LED_INPUT = 2'h0,
    LED_TRIM = 2'h1,
    LED_EXT = 2'h2,
    LED_OFF = 2'h3
  } alc_led_e;

  typedef struct packed {
    logic [21:0] rsvd;
    logic load;
    logic [8:0] tap;
  } alc_tap_s;

  typedef struct packed {
    logic [15:0] thresh;
    logic [8:0] rsvd;
    logic [1:0] led_sel;
    logic pwdn;
    logic dither;
    logic twos;
    logic [1:0] int_dly;
  } alc_mode_s;

  typedef struct packed {
    logic [15:0] gain;
    logic [15:0] offset;
  } alc_trim_s;

  typedef struct packed {
    logic trim_ovld;
    logic adc_ovld;
  } alc_irq_s;
endpackage
`default_nettype wire

// ===== core/alc_skid_buf.sv
`timescale 1ns/1ps
`default_nettype none
module alc_skid_buf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  logic [DEPTH-1:0][WIDTH-1:0] mem, next_mem;
  logic [PTR_W-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [CNT_W-1:0] count, next_count;
  logic push, pop;

  // Handshakes from the fill level
  assign in_ready_out = (count != CNT_W'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out = mem[rd_ptr];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // Pointer and storage update
  always_comb begin
    next_mem = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_mem[wr_ptr] = in_data_in;
      next_wr_ptr = (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mem <= '0;
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      mem <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Buffer checks
  a_fill_bounded: assert property (@(posedge core_clk_in)
    disable iff (!reset_n_in) count <= CNT_W'(DEPTH))
    else $error("buffer count above depth");
  c_buf_full: cover property (@(posedge core_clk_in)
    disable iff (!reset_n_in) !in_ready_out);
endmodule
`default_nettype wire

// ===== sim/alc_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module alc_adc_model (
  output logic sample_clk_out,
  output logic [7:0] pos_out,
  output logic [7:0] neg_out
);
  // Clock stands low between words
  initial begin
    sample_clk_out = 1'h0;
    pos_out = 8'h00;
    neg_out = 8'hFF;
  end
  // One word a period: even bits over the rise, odd bits over the fall
  task automatic send(input logic [15:0] w);
    int k;
    for (k = 0; k < 8; k++) begin
      pos_out[k] = w[2*k];
    end
    neg_out = ~pos_out;
    #100 sample_clk_out = 1'h1;
    #100;
    for (k = 0; k < 8; k++) begin
      pos_out[k] = w[2*k+1];
    end
    neg_out = ~pos_out;
    #100 sample_clk_out = 1'h0;
    #50;
    // Hold time over: show the inverse, never the old word
    pos_out = ~pos_out;
    neg_out = ~pos_out;
    #50;
  endtask
endmodule
`default_nettype wire

// ===== sim/tb_alc_capture_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_alc_capture_top;
  import alc_pkg::*;
  logic clk, rst_n, ext, tready, sclk, awv, wv, br, arv, rr;
  logic pd, di, led_n, aov, tov, awrdy, bv, arrdy, rv, irq, tv;
  logic tld, wrdy;
  logic [7:0] dp, dn;
  logic [6:0] awa, ara;
  logic [31:0] wd, rdat, rdv;
  logic [3:0] ws;
  logic [8:0] tap;
  logic [1:0] bresp, rresp, rsp;
  logic [15:0] td;
  int err_count = 0;
  int n_tests = 0;
  int irq_cnt = 0;
  int tld_cnt = 0;

  alc_adc_model u_alc_adc_model (.sample_clk_out(sclk), .pos_out(dp),
    .neg_out(dn));
  alc_capture_top u_alc_capture_top (
    .core_clk_in(clk), .reset_n_in(rst_n), .data_pair_pos_in(dp),
    .data_pair_neg_in(dn), .sample_clk_in(sclk), .ext_led_src_in(ext),
    .power_down_out(pd), .dither_out(di), .ovld_led_n_out(led_n),
    .adc_ovld_out(aov), .trim_ovld_out(tov), .tap_delay_out(tap),
    .tap_load_out(tld), .s_axi_csr_awaddr_in(awa),
    .s_axi_csr_awvalid_in(awv), .s_axi_csr_awready_out(awrdy),
    .s_axi_csr_wdata_in(wd), .s_axi_csr_wstrb_in(ws),
    .s_axi_csr_wvalid_in(wv), .s_axi_csr_wready_out(wrdy),
    .s_axi_csr_bresp_out(bresp), .s_axi_csr_bvalid_out(bv),
    .s_axi_csr_bready_in(br), .s_axi_csr_araddr_in(ara),
    .s_axi_csr_arvalid_in(arv), .s_axi_csr_arready_out(arrdy),
    .s_axi_csr_rdata_out(rdat), .s_axi_csr_rresp_out(rresp),
    .s_axi_csr_rvalid_out(rv), .s_axi_csr_rready_in(rr),
    .irq_out(irq), .m_axis_tdata_out(td), .m_axis_tvalid_out(tv),
    .m_axis_tready_in(tready));

  // Core clock, 50 ns
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  // Interrupt and tap load pulse counters
  always @(posedge clk) begin
    if (irq === 1'h1) irq_cnt <= irq_cnt + 1;
    if (tld === 1'h1) tld_cnt <= tld_cnt + 1;
  end

  task automatic end_of_test();
    $display("errors %0d comparisons %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Bounded wait for a design flag, checked just after the falling edge
  task automatic wait_hi(ref logic s, input string what);
    int i;
    for (i = 0; s !== 1'h1; i++) begin
      if (i > 40) begin
        err_count++;
        $display("mismatch at %0t: %s timed out", $time, what);
        end_of_test();
      end
      @(negedge clk);
      #1;
    end
  endtask
  // Bus write, address and data together, held until taken
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(negedge clk);
    awa = a;
    wd = d;
    ws = 4'hF;
    awv = 1'h1;
    wv = 1'h1;
    br = 1'h1;
    #1;
    chk(wrdy, 1'h1, "write data take");
    wait_hi(awrdy, "write take");
    @(negedge clk);
    awv = 1'h0;
    wv = 1'h0;
    wait_hi(bv, "write answer");
    rsp = bresp;
    @(negedge clk);
    br = 1'h0;
  endtask
  task automatic rd(input logic [6:0] a);
    @(negedge clk);
    ara = a;
    arv = 1'h1;
    rr = 1'h1;
    #1;
    wait_hi(arrdy, "read take");
    @(negedge clk);
    arv = 1'h0;
    wait_hi(rv, "read answer");
    rdv = rdat;
    rsp = rresp;
    @(negedge clk);
    rr = 1'h0;
  endtask
  task automatic rchk(input logic [6:0] a, input logic [31:0] e, string w);
    rd(a);
    chk(rdv, e, w);
  endtask
  task automatic smp(input logic [15:0] w, e);
    u_alc_adc_model.send(w);
    wait_hi(tv, "sample");
    chk(td, e, "sample word");
    @(negedge clk);
  endtask
  function automatic logic [31:0] mode(logic [15:0] th, logic [1:0] sel,
    logic pw, logic dt);
    return {th, 9'h000, sel, pw, dt, 3'h0};
  endfunction

  task automatic t_reset();
    chk(pd, 1'h0, "power down");
    chk(di, 1'h0, "dither");
    chk(led_n, 1'h1, "led");
    rchk(OFS_TAP, 32'h0, "tap");
    rchk(OFS_MODE, 32'h00040000, "mode");
    rchk(OFS_TRIM, 32'h40000000, "trim");
    rchk(OFS_IEN, 32'h0, "enable");
    rchk(OFS_IFLG, 32'h0, "flags");
  endtask
  task automatic t_regs();
    wr(OFS_TAP, 32'hFFFFFFFF);
    rchk(OFS_TAP, 32'h000003FF, "tap");
    chk(tap, 9'h1FF, "tap pins");
    wr(OFS_TAP, 32'h000001FF);
    chk(tld_cnt, 1, "tap load pulse");
    wr(OFS_MODE, mode(16'h0001, 2'h0, 1'h1, 1'h1));
    chk(pd, 1'h1, "power down");
    chk(di, 1'h1, "dither");
    rchk(OFS_MODE, mode(16'h0001, 2'h0, 1'h1, 1'h1), "mode");
    wr(OFS_MODE, mode(16'h0001, 2'h0, 1'h0, 1'h0));
    chk({pd, di}, 2'h0, "pins low");
    wr(OFS_RSVD_A, 32'hFFFFFFFF);
    rchk(OFS_RSVD_A, 32'h0, "reserved");
    wr(OFS_ISRC, 32'h3);
    rchk(OFS_ISRC, 32'h0, "read only");
    wr(7'h20, 32'h1);
    chk(rsp, RESP_DECERR, "unmapped write");
    rd(7'h20);
    chk(rsp, RESP_DECERR, "unmapped read");
  endtask
  task automatic t_ovld();
    wr(OFS_IEN, 32'h3);
    smp(16'h1234, 16'h1234);
    smp(16'h7FFF, 16'h7FFF);
    @(negedge clk);
    chk(aov, 1'h1, "input overload");
    chk(led_n, 1'h0, "led input");
    chk(irq_cnt, 1, "irq count");
    rchk(OFS_ISRC, 32'h1, "live status");
    rchk(OFS_IFLG, 32'h1, "flag set");
    rchk(OFS_IFLG, 32'h0, "flag clear");
    smp(16'h0100, 16'h0100);
    chk(aov, 1'h0, "overload gone");
  endtask
  task automatic t_trim();
    int i;
    wr(OFS_TRIM, 32'h7FFF0000);
    smp(16'h6000, 16'h7FFF);
    @(negedge clk);
    chk(tov, 1'h1, "trim overload");
    chk(irq_cnt, 2, "irq count");
    rchk(OFS_IFLG, 32'h2, "trim flag");
    ext = 1'h1;
    for (i = 0; i < 4; i++) begin
      wr(OFS_MODE, mode(16'h0001, i[1:0], 1'h0, 1'h0));
      @(negedge clk);
      chk(led_n, 4'b1001 >> i & 1, "led select");
    end
    wr(OFS_MODE, mode(16'h0001, 2'h2, 1'h0, 1'h0));
    ext = 1'h0;
    @(negedge clk);
    @(negedge clk);
    chk(led_n, 1'h1, "led external off");
  endtask
  task automatic t_buf();
    wr(OFS_TRIM, 32'h40000000);
    tready = 1'h0;
    u_alc_adc_model.send(16'h0A0A);
    u_alc_adc_model.send(16'h0B0B);
    u_alc_adc_model.send(16'h0C0C);
    repeat (10) @(negedge clk);
    chk({tv, td}, 17'h10A0A, "stalled head");
    tready = 1'h1;
    @(negedge clk);
    chk({tv, td}, 17'h10B0B, "second word");
    @(negedge clk);
    chk({tv, td}, 17'h10C0C, "held third word");
    @(negedge clk);
    chk(tv, 1'h0, "drained");
    // Two's complement on and one sample of integer delay
    wr(OFS_MODE, 32'h00010005);
    smp(16'h0123, 16'h0C0C);
    smp(16'h0456, 16'h8123);
  endtask

  // Main sequence
  initial begin
    rst_n = 1'h0;
    {ext, awv, wv, br, arv, rr} = 6'h00;
    tready = 1'h1;
    {awa, ara, wd, ws} = 50'h0;
    repeat (20) @(negedge clk);
    rst_n = 1'h1;
    t_reset();
    t_regs();
    t_ovld();
    t_trim();
    t_buf();
    end_of_test();
  end
endmodule
`default_nettype wire
